// *** src/low_speed_osc_cal_control.sv ***
// low-speed clock control: config, trim, oscillator calibration counter, rtc event flags
`timescale 1ns/1ps
`default_nettype none

module low_speed_osc_cal_control
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // avalon-mm slave
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // slow clock pin (asynchronous)
  input wire logic slowClkPin,
  // analog controls
  output logic slowRcFilterOff,
  output logic slowSourceCrystalSel,
  output logic slowRcPowerOn,
  output logic slowCrystalPowerOn,
  output logic [2:0] fastCrystalLoadTrim,
  output logic [1:0] fastCrystalBiasSel,
  output logic [6:0] pllParamField,
  // interrupt requests
  output logic calIrq,
  output logic rtcIrq
);

  // whole block state
  typedef struct packed {
    lsclk_pkg::slow_sync_t slow;
    lsclk_pkg::cfg_t cfg;
    lsclk_pkg::cal_state_t calState;
    logic [13:0] calRun;
    logic [13:0] calibrationCount;
    logic [7:0] wrapCount;
    logic [11:0] slowCycles;
    logic captureDoneFlag;
    logic [15:0] slowTickCount;
    logic [15:0] twoSecondCount;
    logic alarmMatchFlag;
    logic periodicTickFlag;
    logic ack;
    logic [31:0] rdata;
  } state_t;

  state_t cur_ff;
  state_t nxt_ff;

  // window length plus optional extension, in slow cycles
  function automatic logic [11:0] window_len(input logic [2:0] sel, input logic ext);
    window_len = {1'b0, lsclk_pkg::WIN_LEN[sel]} + (ext ? {10'h000, lsclk_pkg::CAL_EXTRA_CYCLES} : 12'h000);
  endfunction : window_len

  // byte-lane merge of one byte written by software
  function automatic logic [7:0] lane(input logic [7:0] old, input logic [31:0] wd, input logic [3:0] be,
                                      input int unsigned idx);
    lane = be[idx] ? wd[8*idx +: 8] : old;
  endfunction : lane

  logic slowRise;
  logic wrAcc;
  logic rdAcc;
  logic [7:0] wb0;
  logic [7:0] wb1;
  logic [7:0] wb3;
  logic [2:0] perIdx;
  logic tickEdge;
  logic alarmHit;

  // edge of the synchronised slow clock; the meta flop feeds only the sync flop
  assign slowRise = cur_ff.slow.sync & ~cur_ff.slow.prev;
  // one wait cycle per access keeps the read path registered; writes land on the edge where waitrequest is low
  assign wrAcc = avs_write & cur_ff.ack;
  assign rdAcc = avs_read & ~cur_ff.ack;
  assign avs_waitrequest = (avs_read | avs_write) & ~cur_ff.ack;
  assign wb0 = avs_writedata[7:0] & {8{avs_byteenable[0]}};
  assign wb1 = avs_writedata[15:8] & {8{avs_byteenable[1]}};
  assign wb3 = avs_writedata[31:24] & {8{avs_byteenable[3]}};
  assign perIdx = cur_ff.cfg.tickPeriod;
  // period boundary: slow edge where the tick count low 12 bits are all ones and the bits picked by sel are set; sel 0 to 4 give 0.125, 0.125, 0.25, 0.5, 1 s
  assign tickEdge = slowRise && (cur_ff.slowTickCount[lsclk_pkg::TICK_EIGHTH_LOG2 - 1:0] == 12'hFFF) &&
                    ((perIdx == 3'h0) || (cur_ff.slowTickCount[15:12] & ((4'h1 << (perIdx - 3'h1)) - 4'h1) |
                    ((perIdx >= 3'h5) ? 4'hF : 4'h0)) == (((4'h1 << (perIdx - 3'h1)) - 4'h1) |
                    ((perIdx >= 3'h5) ? 4'hF : 4'h0)) && ((perIdx < 3'h5) || (perIdx == 3'h5) ||
                    ((cur_ff.twoSecondCount & ((16'h1 << (perIdx - 3'h5)) - 16'h1)) ==
                    ((16'h1 << (perIdx - 3'h5)) - 16'h1))));
  // alarm compare, lowest bit optionally ignored
  assign alarmHit = (cur_ff.twoSecondCount == cur_ff.cfg.alarmValue[31:16]) &&
                    ((cur_ff.slowTickCount | {15'h0000, cur_ff.cfg.ignoreBit0}) ==
                    (cur_ff.cfg.alarmValue[15:0] | {15'h0000, cur_ff.cfg.ignoreBit0}));

  // next-state logic
  always_comb
  begin
    nxt_ff = cur_ff;
    nxt_ff.slow.meta = slowClkPin;
    nxt_ff.slow.sync = cur_ff.slow.meta;
    nxt_ff.slow.prev = cur_ff.slow.sync;
    nxt_ff.ack = (avs_read | avs_write) & ~cur_ff.ack;

    // rtc counters on the slow clock edges
    if (slowRise)
    begin
      nxt_ff.slowTickCount = cur_ff.slowTickCount + 16'h0001;
      if (cur_ff.slowTickCount == 16'hFFFF)
      begin
        nxt_ff.twoSecondCount = cur_ff.twoSecondCount + 16'h0001;
      end
    end

    // calibration counter
    unique case (cur_ff.calState)
      lsclk_pkg::CAL_IDLE:
      begin
        if (cur_ff.cfg.countEnable && slowRise)
        begin
          nxt_ff.calState = lsclk_pkg::CAL_COUNT;
          nxt_ff.calRun = 14'h0000;
          nxt_ff.slowCycles = 12'h000;
        end
      end
      lsclk_pkg::CAL_COUNT:
      begin
        nxt_ff.calRun = cur_ff.calRun + 14'h0001;
        if (cur_ff.calRun == 14'h3FFF)
        begin
          nxt_ff.wrapCount = cur_ff.wrapCount + 8'h01;
        end
        if (slowRise)
        begin
          nxt_ff.slowCycles = cur_ff.slowCycles + 12'h001;
          if (cur_ff.slowCycles + 12'h001 == window_len(cur_ff.cfg.windowSel, cur_ff.cfg.endExtend))
          begin
            nxt_ff.calibrationCount = cur_ff.calRun + 14'h0001;
            nxt_ff.calState = lsclk_pkg::CAL_PAUSE;
          end
        end
        if (!cur_ff.cfg.countEnable)
        begin
          nxt_ff.calState = lsclk_pkg::CAL_IDLE;
        end
      end
      lsclk_pkg::CAL_PAUSE:
      begin
        if (!cur_ff.cfg.countEnable)
        begin
          nxt_ff.calState = lsclk_pkg::CAL_IDLE;
        end
        else if (slowRise)
        begin
          nxt_ff.calState = lsclk_pkg::CAL_COUNT;
          nxt_ff.calRun = 14'h0000;
          nxt_ff.slowCycles = 12'h000;
        end
      end
    endcase

    // software writes
    if (wrAcc)
    begin
      unique case (avs_address)
        lsclk_pkg::OFS_LS_CONFIG:
        begin
          if (avs_byteenable[0])
          begin
            nxt_ff.cfg.filtOff = avs_writedata[lsclk_pkg::LS_FILT_BIT];
            nxt_ff.cfg.crystalSel = avs_writedata[lsclk_pkg::LS_XSEL_BIT];
            nxt_ff.cfg.rcPowerOn = avs_writedata[lsclk_pkg::LS_RCPON_BIT];
            nxt_ff.cfg.crystalPowerOn = avs_writedata[lsclk_pkg::LS_XTPON_BIT];
          end
        end
        lsclk_pkg::OFS_FAST_TRIM:
        begin
          if (avs_byteenable[0])
          begin
            nxt_ff.cfg.loadTrim = avs_writedata[lsclk_pkg::TRIM_LOAD_LSB +: 3];
            nxt_ff.cfg.biasSel = avs_writedata[lsclk_pkg::TRIM_BIAS_LSB +: 2];
          end
        end
        lsclk_pkg::OFS_CAL_COUNT:
        begin
          if (wb1[lsclk_pkg::CNT_WRAP_BIT - 8])
          begin
            nxt_ff.wrapCount = 8'h00;
          end
        end
        lsclk_pkg::OFS_CAL_CTRL:
        begin
          if (avs_byteenable[0])
          begin
            nxt_ff.cfg.endExtend = avs_writedata[lsclk_pkg::CTL_EXT_BIT];
            nxt_ff.cfg.countEnable = avs_writedata[lsclk_pkg::CTL_EN_BIT];
            nxt_ff.cfg.irqEnable = avs_writedata[lsclk_pkg::CTL_IE_BIT];
            nxt_ff.cfg.windowSel = avs_writedata[lsclk_pkg::CTL_WIN_LSB +: 3];
          end
        end
        lsclk_pkg::OFS_PLL_PARAM:
        begin
          if (avs_byteenable[0])
          begin
            nxt_ff.cfg.pllParam = avs_writedata[6:0];
          end
        end
        lsclk_pkg::OFS_RTC_MODE:
        begin
          if (avs_byteenable[0])
          begin
            nxt_ff.cfg.alarmEnable = avs_writedata[lsclk_pkg::RM_ALARM_EN_BIT];
            nxt_ff.cfg.tickEnable = avs_writedata[lsclk_pkg::RM_TICK_EN_BIT];
            nxt_ff.cfg.ignoreBit0 = avs_writedata[lsclk_pkg::RM_IGN_B0_BIT];
            nxt_ff.cfg.tickPeriod = avs_writedata[lsclk_pkg::RM_PER_LSB +: 3];
          end
        end
        lsclk_pkg::OFS_ALARM_VALUE:
        begin
          nxt_ff.cfg.alarmValue = {lane(cur_ff.cfg.alarmValue[31:24], avs_writedata, avs_byteenable, 3),
                                   lane(cur_ff.cfg.alarmValue[23:16], avs_writedata, avs_byteenable, 2),
                                   lane(cur_ff.cfg.alarmValue[15:8], avs_writedata, avs_byteenable, 1),
                                   lane(cur_ff.cfg.alarmValue[7:0], avs_writedata, avs_byteenable, 0)};
        end
        default:
        begin
          nxt_ff.cfg = cur_ff.cfg;
        end
      endcase
    end

    // flags: software clear first, hardware set afterwards so a set in the same cycle wins
    if (wrAcc && avs_address == lsclk_pkg::OFS_CAL_COUNT && wb1[lsclk_pkg::CNT_DONE_BIT - 8])
    begin
      nxt_ff.captureDoneFlag = 1'b0;
    end
    if (wrAcc && avs_address == lsclk_pkg::OFS_RTC_FLAGS && cur_ff.cfg.alarmEnable && wb0[lsclk_pkg::RF_ACLR_BIT])
    begin
      nxt_ff.alarmMatchFlag = 1'b0;
    end
    if (wrAcc && avs_address == lsclk_pkg::OFS_RTC_FLAGS && cur_ff.cfg.tickEnable && wb0[lsclk_pkg::RF_TCLR_BIT])
    begin
      nxt_ff.periodicTickFlag = 1'b0;
    end
    if (cur_ff.calState == lsclk_pkg::CAL_COUNT && nxt_ff.calState == lsclk_pkg::CAL_PAUSE)
    begin
      nxt_ff.captureDoneFlag = 1'b1;
    end
    if (cur_ff.cfg.alarmEnable && slowRise && alarmHit)
    begin
      nxt_ff.alarmMatchFlag = 1'b1;
    end
    if (cur_ff.cfg.tickEnable && tickEdge)
    begin
      nxt_ff.periodicTickFlag = 1'b1;
    end

    // registered read data; unmapped offsets read zero
    if (rdAcc)
    begin
      nxt_ff.rdata = 32'h00000000;
      unique case (avs_address)
        lsclk_pkg::OFS_LS_CONFIG:
        begin
          nxt_ff.rdata[lsclk_pkg::LS_PIN_BIT] = cur_ff.slow.sync;
          nxt_ff.rdata[lsclk_pkg::LS_FILT_BIT] = cur_ff.cfg.filtOff;
          nxt_ff.rdata[lsclk_pkg::LS_XSEL_BIT] = cur_ff.cfg.crystalSel;
          nxt_ff.rdata[lsclk_pkg::LS_RCPON_BIT] = cur_ff.cfg.rcPowerOn;
          nxt_ff.rdata[lsclk_pkg::LS_XTPON_BIT] = cur_ff.cfg.crystalPowerOn;
        end
        lsclk_pkg::OFS_FAST_TRIM:
        begin
          nxt_ff.rdata[lsclk_pkg::TRIM_LOAD_LSB +: 3] = cur_ff.cfg.loadTrim;
          nxt_ff.rdata[lsclk_pkg::TRIM_BIAS_LSB +: 2] = cur_ff.cfg.biasSel;
        end
        lsclk_pkg::OFS_CAL_COUNT:
        begin
          nxt_ff.rdata[lsclk_pkg::CNT_DONE_BIT] = cur_ff.captureDoneFlag;
          nxt_ff.rdata[lsclk_pkg::CNT_WRAP_BIT] = |cur_ff.wrapCount;
          nxt_ff.rdata[13:0] = cur_ff.calibrationCount;
        end
        lsclk_pkg::OFS_CAL_WRAP:
        begin
          nxt_ff.rdata[7:0] = cur_ff.wrapCount;
        end
        lsclk_pkg::OFS_CAL_CTRL:
        begin
          nxt_ff.rdata[lsclk_pkg::CTL_EXT_BIT] = cur_ff.cfg.endExtend;
          nxt_ff.rdata[lsclk_pkg::CTL_EN_BIT] = cur_ff.cfg.countEnable;
          nxt_ff.rdata[lsclk_pkg::CTL_IE_BIT] = cur_ff.cfg.irqEnable;
          nxt_ff.rdata[lsclk_pkg::CTL_PAUSE_BIT] = (cur_ff.calState != lsclk_pkg::CAL_COUNT);
          nxt_ff.rdata[lsclk_pkg::CTL_WIN_LSB +: 3] = cur_ff.cfg.windowSel;
        end
        lsclk_pkg::OFS_PLL_PARAM:
        begin
          nxt_ff.rdata[6:0] = cur_ff.cfg.pllParam;
        end
        lsclk_pkg::OFS_RTC_FLAGS:
        begin
          nxt_ff.rdata[lsclk_pkg::RF_ALARM_BIT] = cur_ff.alarmMatchFlag;
          nxt_ff.rdata[lsclk_pkg::RF_TICK_BIT] = cur_ff.periodicTickFlag;
          nxt_ff.rdata[lsclk_pkg::RF_ACLR_BIT] = ~cur_ff.cfg.alarmEnable;
          nxt_ff.rdata[lsclk_pkg::RF_TCLR_BIT] = ~cur_ff.cfg.tickEnable;
        end
        lsclk_pkg::OFS_RTC_MODE:
        begin
          nxt_ff.rdata[lsclk_pkg::RM_ALARM_EN_BIT] = cur_ff.cfg.alarmEnable;
          nxt_ff.rdata[lsclk_pkg::RM_TICK_EN_BIT] = cur_ff.cfg.tickEnable;
          nxt_ff.rdata[lsclk_pkg::RM_IGN_B0_BIT] = cur_ff.cfg.ignoreBit0;
          nxt_ff.rdata[lsclk_pkg::RM_PER_LSB +: 3] = cur_ff.cfg.tickPeriod;
        end
        lsclk_pkg::OFS_ALARM_VALUE:
        begin
          nxt_ff.rdata = cur_ff.cfg.alarmValue;
        end
        lsclk_pkg::OFS_RTC_COUNT:
        begin
          nxt_ff.rdata = {cur_ff.twoSecondCount, cur_ff.slowTickCount};
        end
        default:
        begin
          nxt_ff.rdata = 32'h00000000;
        end
      endcase
    end
  end

  // state register; reset takes constants only
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      cur_ff <= '0;
      cur_ff.cfg.filtOff <= lsclk_pkg::LS_FILT_OFF_RST;
      cur_ff.cfg.crystalSel <= lsclk_pkg::LS_XSEL_RST;
      cur_ff.cfg.rcPowerOn <= lsclk_pkg::LS_RCPON_RST;
      cur_ff.cfg.crystalPowerOn <= lsclk_pkg::LS_XTPON_RST;
      cur_ff.cfg.loadTrim <= lsclk_pkg::TRIM_LOAD_RST;
      cur_ff.cfg.biasSel <= lsclk_pkg::TRIM_BIAS_RST;
      cur_ff.cfg.windowSel <= lsclk_pkg::CTL_WIN_RST;
      cur_ff.cfg.pllParam <= lsclk_pkg::PLL_PARAM_RST;
      cur_ff.cfg.tickPeriod <= lsclk_pkg::RM_PER_RST;
      cur_ff.calState <= lsclk_pkg::CAL_IDLE;
    end
    else
    begin
      cur_ff <= nxt_ff;
    end
  end

  // outputs
  assign avs_readdata = cur_ff.rdata;
  assign slowRcFilterOff = cur_ff.cfg.filtOff;
  assign slowSourceCrystalSel = cur_ff.cfg.crystalSel;
  assign slowRcPowerOn = cur_ff.cfg.rcPowerOn;
  assign slowCrystalPowerOn = cur_ff.cfg.crystalPowerOn;
  assign fastCrystalLoadTrim = cur_ff.cfg.loadTrim;
  assign fastCrystalBiasSel = cur_ff.cfg.biasSel;
  assign pllParamField = cur_ff.cfg.pllParam;
  assign calIrq = cur_ff.cfg.irqEnable & cur_ff.captureDoneFlag;
  assign rtcIrq = cur_ff.alarmMatchFlag | cur_ff.periodicTickFlag;

endmodule : low_speed_osc_cal_control
`default_nettype wire

// *** inc/lsclk_pkg.sv ***
// package: register map, field positions, reset values and timing constants for the low-speed clock control block
package lsclk_pkg;

  // register byte offsets: each register takes one aligned 32-bit word
  localparam logic [5:0] OFS_LS_CONFIG = 6'h00;
  localparam logic [5:0] OFS_FAST_TRIM = 6'h04;
  localparam logic [5:0] OFS_CAL_COUNT = 6'h08;
  localparam logic [5:0] OFS_CAL_WRAP = 6'h0C;
  localparam logic [5:0] OFS_CAL_CTRL = 6'h10;
  localparam logic [5:0] OFS_PLL_PARAM = 6'h14;
  localparam logic [5:0] OFS_RTC_FLAGS = 6'h18;
  localparam logic [5:0] OFS_RTC_MODE = 6'h1C;
  localparam logic [5:0] OFS_ALARM_VALUE = 6'h20;
  localparam logic [5:0] OFS_RTC_COUNT = 6'h24;

  // low-speed oscillator config fields
  localparam int unsigned LS_PIN_BIT = 7;
  localparam int unsigned LS_FILT_BIT = 3;
  localparam int unsigned LS_XSEL_BIT = 2;
  localparam int unsigned LS_RCPON_BIT = 1;
  localparam int unsigned LS_XTPON_BIT = 0;
  localparam logic LS_FILT_OFF_RST = 1'b0;
  localparam logic LS_XSEL_RST = 1'b0;
  localparam logic LS_RCPON_RST = 1'b1;
  localparam logic LS_XTPON_RST = 1'b0;

  // fast crystal trim fields
  localparam int unsigned TRIM_LOAD_LSB = 4;
  localparam int unsigned TRIM_BIAS_LSB = 0;
  localparam logic [2:0] TRIM_LOAD_RST = 3'h3;
  localparam logic [1:0] TRIM_BIAS_RST = 2'h2;

  // calibration count fields
  localparam int unsigned CNT_DONE_BIT = 15;
  localparam int unsigned CNT_WRAP_BIT = 14;
  localparam int unsigned CNT_W = 14;
  localparam int unsigned WRAP_W = 8;

  // calibration control fields
  localparam int unsigned CTL_EXT_BIT = 6;
  localparam int unsigned CTL_EN_BIT = 5;
  localparam int unsigned CTL_IE_BIT = 4;
  localparam int unsigned CTL_PAUSE_BIT = 3;
  localparam int unsigned CTL_WIN_LSB = 0;
  localparam logic [2:0] CTL_WIN_RST = 3'h1;
  localparam logic [1:0] CAL_EXTRA_CYCLES = 2'h2;

  // pll parameter field
  localparam logic [6:0] PLL_PARAM_RST = 7'h02;

  // rtc flags / mode fields
  localparam int unsigned RF_ALARM_BIT = 7;
  localparam int unsigned RF_TICK_BIT = 6;
  localparam int unsigned RF_ACLR_BIT = 5;
  localparam int unsigned RF_TCLR_BIT = 4;
  localparam int unsigned RM_ALARM_EN_BIT = 5;
  localparam int unsigned RM_TICK_EN_BIT = 4;
  localparam int unsigned RM_IGN_B0_BIT = 3;
  localparam int unsigned RM_PER_LSB = 0;
  localparam logic [2:0] RM_PER_RST = 3'h2;

  // slow tick count bits per 0.125 s period (4096 ticks)
  localparam int unsigned TICK_EIGHTH_LOG2 = 12;

  // calibration window lengths in slow clock cycles, indexed by window code
  localparam logic [10:0] WIN_LEN [8] = '{11'd1, 11'd2, 11'd4, 11'd32, 11'd64, 11'd128, 11'd1024, 11'd2047};

  typedef enum logic [1:0] {CAL_IDLE, CAL_COUNT, CAL_PAUSE} cal_state_t;

  // synchroniser and edge history for the slow clock
  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
  } slow_sync_t;

  // software configuration bits
  typedef struct packed {
    logic filtOff;
    logic crystalSel;
    logic rcPowerOn;
    logic crystalPowerOn;
    logic [2:0] loadTrim;
    logic [1:0] biasSel;
    logic endExtend;
    logic countEnable;
    logic irqEnable;
    logic [2:0] windowSel;
    logic [6:0] pllParam;
    logic alarmEnable;
    logic tickEnable;
    logic ignoreBit0;
    logic [2:0] tickPeriod;
    logic [31:0] alarmValue;
  } cfg_t;

endpackage : lsclk_pkg

// *** tb/low_speed_osc_cal_control_checker.sv ***
// checker: bus timing, control outputs and read-back relations of the low-speed clock block
`timescale 1ns/1ps
`default_nettype none
module low_speed_osc_cal_control_checker
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // avalon-mm slave
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // controls and interrupt
  input wire logic slowRcFilterOff,
  input wire logic slowSourceCrystalSel,
  input wire logic slowRcPowerOn,
  input wire logic slowCrystalPowerOn,
  input wire logic [2:0] fastCrystalLoadTrim,
  input wire logic [1:0] fastCrystalBiasSel,
  input wire logic calIrq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic wrAcc, rdAcc, cfgWr, trimWr;
  logic ieSh_ff, calEnSh_ff, alarmEnSh_ff, tickEnSh_ff;
  // accepted transfers; writes count on lane 0 only
  assign wrAcc = avs_write && !avs_waitrequest && avs_byteenable[0];
  assign rdAcc = avs_read && !avs_waitrequest;
  assign cfgWr = wrAcc && avs_address == lsclk_pkg::OFS_LS_CONFIG;
  assign trimWr = wrAcc && avs_address == lsclk_pkg::OFS_FAST_TRIM;
  // shadow of enable bits, since the checker cannot see the register bank
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      ieSh_ff <= 1'b0;
      calEnSh_ff <= 1'b0;
      alarmEnSh_ff <= 1'b0;
      tickEnSh_ff <= 1'b0;
    end
    else if (wrAcc && avs_address == lsclk_pkg::OFS_CAL_CTRL)
    begin
      ieSh_ff <= avs_writedata[4];
      calEnSh_ff <= avs_writedata[5];
    end
    else if (wrAcc && avs_address == lsclk_pkg::OFS_RTC_MODE)
    begin
      alarmEnSh_ff <= avs_writedata[5];
      tickEnSh_ff <= avs_writedata[4];
    end
  end
  property p_ack;
    $rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest;
  endproperty
  a_ack: assert property (p_ack) else $error("answer not one cycle after request");
  property p_cfg;
    cfgWr |=> {slowRcFilterOff, slowSourceCrystalSel, slowRcPowerOn, slowCrystalPowerOn} == $past(avs_writedata[3:0]);
  endproperty
  a_cfg: assert property (p_cfg) else $error("config outputs differ from write");
  property p_cfgHold;
    !cfgWr |=> $stable({slowRcFilterOff, slowSourceCrystalSel, slowRcPowerOn, slowCrystalPowerOn});
  endproperty
  a_cfgHold: assert property (p_cfgHold) else $error("config output moved without write");
  property p_trim;
    trimWr |=> {fastCrystalLoadTrim, fastCrystalBiasSel} == $past({avs_writedata[6:4], avs_writedata[1:0]});
  endproperty
  a_trim: assert property (p_trim) else $error("trim outputs differ from write");
  property p_irq;
    calIrq |-> ieSh_ff;
  endproperty
  a_irq: assert property (p_irq) else $error("calibration irq while disabled");
  property p_aclr;
    rdAcc && avs_address == lsclk_pkg::OFS_RTC_FLAGS && !alarmEnSh_ff |-> avs_readdata[5];
  endproperty
  a_aclr: assert property (p_aclr) else $error("alarm clear bit low while disabled");
  property p_tclr;
    rdAcc && avs_address == lsclk_pkg::OFS_RTC_FLAGS && !tickEnSh_ff |-> avs_readdata[4];
  endproperty
  a_tclr: assert property (p_tclr) else $error("tick clear bit low while disabled");
  property p_paused;
    rdAcc && avs_address == lsclk_pkg::OFS_CAL_CTRL && !calEnSh_ff |-> avs_readdata[3];
  endproperty
  a_paused: assert property (p_paused) else $error("paused bit low while disabled");
  c_calIrq: cover property (calIrq);
  c_done: cover property (rdAcc && avs_address == lsclk_pkg::OFS_CAL_COUNT && avs_readdata[15]);
  c_cfg: cover property (cfgWr);
endmodule : low_speed_osc_cal_control_checker
bind low_speed_osc_cal_control low_speed_osc_cal_control_checker u_chk (.clk_sys, .rst, .avs_address, .avs_read,
  .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .slowRcFilterOff,
  .slowSourceCrystalSel, .slowRcPowerOn, .slowCrystalPowerOn, .fastCrystalLoadTrim, .fastCrystalBiasSel, .calIrq);
`default_nettype wire

// *** tb/low_speed_osc_cal_control_tb_top.sv ***
// testbench: register reset values, controls, calibration counts and rtc flags
`timescale 1ns/1ps
`default_nettype none
module low_speed_osc_cal_control_tb_top;
  logic clk_sys = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, slowClkPin = 1'b0, slowRun = 1'b0;
  logic [5:0] avs_address = 6'h00;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic [3:0] avs_byteenable = 4'hF;
  logic avs_waitrequest, fOff, xSel, rcOn, xtOn, calIrq, rtcIrq;
  logic [2:0] loadTrim;
  logic [1:0] biasSel;
  logic [6:0] pll;
  int mismatches = 0, num_checks = 0, cycles = 0, slowCnt = 0, slowHalf = 9;
  low_speed_osc_cal_control dut (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .slowClkPin(slowClkPin),
    .slowRcFilterOff(fOff), .slowSourceCrystalSel(xSel), .slowRcPowerOn(rcOn), .slowCrystalPowerOn(xtOn),
    .fastCrystalLoadTrim(loadTrim), .fastCrystalBiasSel(biasSel), .pllParamField(pll), .calIrq(calIrq),
    .rtcIrq(rtcIrq));
  always #10 clk_sys = ~clk_sys;
  // slow clock period is 2*(slowHalf+1) system cycles; 20 keeps synchroniser delay small against a period
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 90000)
    begin
      mismatches++;
      conclude();
    end
    if (slowRun)
    begin
      slowCnt <= (slowCnt >= slowHalf) ? 0 : slowCnt + 1;
      if (slowCnt >= slowHalf)
        slowClkPin <= ~slowClkPin;
    end
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : conclude
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check
  // one transfer, held until waitrequest is seen low at a rising edge
  task automatic bus(input logic [5:0] a, input logic wr, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    if (avs_waitrequest !== 1'b0)
      check(32'h1, 32'h0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_sys);
  endtask : bus
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(a, 1'b1, d, q);
  endtask : wr
  task automatic rdc(input logic [5:0] a, input logic [31:0] mask, input logic [31:0] exp);
    logic [31:0] q;
    bus(a, 1'b0, 32'h0, q);
    check(q & mask, exp);
  endtask : rdc
  task automatic t_reset();
    logic [5:0] adr [9] = '{6'h00, 6'h04, 6'h08, 6'h10, 6'h14, 6'h18, 6'h1C, 6'h20, 6'h3C};
    logic [31:0] msk [9] = '{32'hFF, 32'hFF, 32'hC000, 32'hFF, 32'hFF, 32'hFF, 32'h3F, 32'hFFFFFFFF, 32'hFFFFFFFF};
    logic [31:0] exv [9] = '{32'h02, 32'h32, 32'h0, 32'h09, 32'h02, 32'h30, 32'h02, 32'h0, 32'h0};
    check(32'({fOff, xSel, rcOn, xtOn, loadTrim, biasSel, pll}), 32'h2702);
    for (int i = 0; i < 9; i++)
      rdc(adr[i], msk[i], exv[i]);
    $display("reset test done");
  endtask : t_reset
  task automatic t_ctrl();
    wr(lsclk_pkg::OFS_LS_CONFIG, 32'hFF);
    check(32'({fOff, xSel, rcOn, xtOn}), 32'hF);
    rdc(lsclk_pkg::OFS_LS_CONFIG, 32'hFF, 32'h0F);
    slowClkPin <= 1'b1;
    repeat (5) @(posedge clk_sys);
    rdc(lsclk_pkg::OFS_LS_CONFIG, 32'hFF, 32'h8F);
    slowClkPin <= 1'b0;
    wr(lsclk_pkg::OFS_LS_CONFIG, 32'h00);
    check(32'({fOff, xSel, rcOn, xtOn}), 32'h0);
    wr(lsclk_pkg::OFS_FAST_TRIM, 32'hFF);
    rdc(lsclk_pkg::OFS_FAST_TRIM, 32'hFF, 32'h73);
    check(32'({loadTrim, biasSel}), 32'h1F);
    $display("control test done");
  endtask : t_ctrl
  task automatic poll(output logic [31:0] q);
    int n;
    n = 0;
    do
    begin
      bus(lsclk_pkg::OFS_CAL_COUNT, 1'b0, 32'h0, q);
      n++;
    end
    while (q[15] !== 1'b1 && n < 9000);
  endtask : poll
  task automatic t_cal();
    logic [31:0] q;
    logic [7:0] ctl [4] = '{8'h30, 8'h32, 8'h70, 8'h26};
    logic [15:0] exc [4] = '{16'h8014, 16'h8050, 16'h803C, 16'hD000};
    slowRun <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      wr(lsclk_pkg::OFS_CAL_CTRL, 32'(ctl[i]));
      poll(q);
      check(32'(q[15:0]), 32'(exc[i]));
      check(32'(calIrq), 32'(ctl[i][4]));
      wr(lsclk_pkg::OFS_CAL_CTRL, 32'h00);
      check(32'(calIrq), 32'h0);
      rdc(lsclk_pkg::OFS_CAL_CTRL, 32'hFF, 32'h08);
      if (i < 3)
        wr(lsclk_pkg::OFS_CAL_COUNT, 32'h8000);
      if (i < 3)
        rdc(lsclk_pkg::OFS_CAL_COUNT, 32'hC000, 32'h0);
    end
    rdc(lsclk_pkg::OFS_CAL_WRAP, 32'hFF, 32'h01);
    wr(lsclk_pkg::OFS_CAL_COUNT, 32'h4000);
    rdc(lsclk_pkg::OFS_CAL_WRAP, 32'hFF, 32'h00);
    rdc(lsclk_pkg::OFS_CAL_COUNT, 32'hC000, 32'h8000);
    $display("calibration test done");
  endtask : t_cal
  task automatic t_rtc();
    logic [31:0] q;
    int n;
    wr(lsclk_pkg::OFS_RTC_MODE, 32'h22);
    rdc(lsclk_pkg::OFS_RTC_FLAGS, 32'hFF, 32'h10);
    bus(lsclk_pkg::OFS_RTC_COUNT, 1'b0, 32'h0, q);
    wr(lsclk_pkg::OFS_ALARM_VALUE, q + 32'd4);
    n = 0;
    do
    begin
      bus(lsclk_pkg::OFS_RTC_FLAGS, 1'b0, 32'h0, q);
      n++;
    end
    while (q[7] !== 1'b1 && n < 100);
    check(q & 32'hF0, 32'h90);
    check(32'(rtcIrq), 32'h1);
    wr(lsclk_pkg::OFS_RTC_FLAGS, 32'h20);
    rdc(lsclk_pkg::OFS_RTC_FLAGS, 32'hFF, 32'h10);
    wr(lsclk_pkg::OFS_RTC_FLAGS, 32'hC0);
    rdc(lsclk_pkg::OFS_RTC_FLAGS, 32'hFF, 32'h10);
    check(32'(rtcIrq), 32'h0);
    $display("rtc test done");
  endtask : t_rtc
  // fastest period with a fast slow clock, so 4096 ticks fit in the run
  task automatic t_tick();
    logic [31:0] q;
    int n;
    slowHalf <= 1;
    wr(lsclk_pkg::OFS_RTC_MODE, 32'h10);
    n = 0;
    do
    begin
      bus(lsclk_pkg::OFS_RTC_FLAGS, 1'b0, 32'h0, q);
      n++;
    end
    while (q[6] !== 1'b1 && n < 6000);
    check(q & 32'hF0, 32'h60);
    check(32'(rtcIrq), 32'h1);
    bus(lsclk_pkg::OFS_RTC_COUNT, 1'b0, 32'h0, q);
    check(32'(q[11:0] < 12'h008), 32'h1);
    wr(lsclk_pkg::OFS_RTC_FLAGS, 32'h10);
    rdc(lsclk_pkg::OFS_RTC_FLAGS, 32'hFF, 32'h20);
    check(32'(rtcIrq), 32'h0);
    $display("tick test done");
  endtask : t_tick
  initial
  begin
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    t_reset();
    t_ctrl();
    t_cal();
    t_rtc();
    t_tick();
    conclude();
  end
endmodule : low_speed_osc_cal_control_tb_top
`default_nettype wire
